/* shared/sfio_pkg.sv */
// Overview of operation
// [R1] Analog port: 4-bit latch at data address 72H, push-pull output drive.
// [R2] Analog port per-bit direction at 1CH; input reads pin, output reads latch.
// [R3] Reset: analog port directions 0, latch 0.
// [R4] Nibble 1BH per bit: 0 keeps port pin, 1 selects analog input.
// [R5] Any analog select bit set turns input port pin 1 into reference.
// [R6] Converter channel comes from bits 0 and 1 of nibble 22H.
// [R7] Reset clears analog selects and channel field to 0.
// [R8] Software sets analog select after reset and keeps direction 0.
// [R9] Serial port: latch at 73H, open-drain, per-bit direction at 2BH.
// [R10] Nibble 0DH bit enables pull-up on matching serial port pin.
// [R11] Reset clears serial directions and latch; direction change keeps latch.
// [R12] Bit 0 of 0BH hands pins 0..2 to serial clock, out, in.
// [R13] Bit 3 of 0BH routes timer output to pin 3; set on reset, toggle on match.
// [R14] Serial port read: pin for serial in, external clock and input-direction bits outside serial/timer roles, else latch.
// [R15] Open-drain port: latch at 6EH, group direction bit 2 of 2CH.
// [R16] Bit 2 of 0CH enables pull-ups on all open-drain port pins.
// [R17] Reset clears open-drain group direction and latch.
// [R18] Input-only port at 6FH returns two pins low, upper bits 0.
// [R19] Writes to the input-only port are ignored.
// [R20] Bit 1 of input-only port reads 0 while it is the reference input.
// [R21] Port writes update latches regardless of direction.
// [R22] Undriven pins: inputs and open-drain outputs at 1 are released.
package sfio_pkg;
    localparam logic [6:0] SFIO_ADDR_FUNC_SEL = 7'h0b;
    localparam logic [6:0] SFIO_ADDR_GROUP_PU = 7'h0c;
    localparam logic [6:0] SFIO_ADDR_SER_PU = 7'h0d;
    localparam logic [6:0] SFIO_ADDR_ANA_SEL = 7'h1b;
    localparam logic [6:0] SFIO_ADDR_ANA_DIR = 7'h1c;
    localparam logic [6:0] SFIO_ADDR_CHAN_SEL = 7'h22;
    localparam logic [6:0] SFIO_ADDR_SER_DIR = 7'h2b;
    localparam logic [6:0] SFIO_ADDR_GROUP_DIR = 7'h2c;
    localparam logic [6:0] SFIO_ADDR_OD_DATA = 7'h6e;
    localparam logic [6:0] SFIO_ADDR_IN_DATA = 7'h6f;
    localparam logic [6:0] SFIO_ADDR_ANA_DATA = 7'h72;
    localparam logic [6:0] SFIO_ADDR_SER_DATA = 7'h73;
    localparam int SFIO_SERIAL_EN_BIT = 0;
    localparam int SFIO_TIMER_OUT_BIT = 3;
    localparam int SFIO_OD_GROUP_BIT = 2;
    localparam int SFIO_REF_PIN_BIT = 1;
    localparam int SFIO_SCK_PIN = 0;
    localparam int SFIO_SO_PIN = 1;
    localparam int SFIO_SI_PIN = 2;
    localparam int SFIO_TMR_PIN = 3;
    localparam logic [3:0] SFIO_NIB_RESET = 4'h0;
    localparam logic [1:0] SFIO_CHAN_MASK = 2'h3;
endpackage

/* logic/sfio_ports.sv */
`timescale 1ns/1ps
module sfio_ports (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [6:0] rf_addr,
    input wire logic rf_wr,
    input wire logic [3:0] rf_wdata,
    input wire logic [6:0] dm_addr,
    input wire logic dm_wr,
    input wire logic [3:0] dm_wdata,
    output logic [3:0] rf_rdata,
    output logic [3:0] dm_rdata,
    input wire logic [3:0] ana_pin_in,
    output logic [3:0] ana_pin_out,
    output logic [3:0] ana_pin_oe,
    output logic [3:0] analog_pin_enable,
    output logic [1:0] converter_channel,
    output logic reference_pin_enable,
    input wire logic [3:0] ser_pin_in,
    output logic [3:0] ser_pin_out,
    output logic [3:0] ser_pin_oe,
    output logic [3:0] ser_pullup_en,
    input wire logic serial_clk_internal,
    input wire logic serial_clk_out,
    input wire logic serial_data_out,
    output logic serial_data_in,
    output logic serial_clk_in,
    input wire logic timer_reset,
    input wire logic timer_match,
    input wire logic [3:0] od_pin_in,
    output logic [3:0] od_pin_out,
    output logic [3:0] od_pin_oe,
    output logic [3:0] od_pullup_en,
    input wire logic [1:0] in_pin
);
    logic [3:0] func_sel_r;
    logic [3:0] group_pu_r;
    logic [3:0] ser_pu_r;
    logic [3:0] ana_sel_r;
    logic [3:0] ana_dir_r;
    logic [3:0] chan_sel_r;
    logic [3:0] ser_dir_r;
    logic [3:0] group_dir_r;
    logic [3:0] ana_lat_r;
    logic [3:0] ser_lat_r;
    logic [3:0] od_lat_r;
    logic timer_out_r;
    logic serial_on;
    logic timer_on;
    logic [3:0] ser_drive;
    logic [3:0] ser_use_pin;
    logic [3:0] od_dir;
    logic [3:0] in_read;
    logic [3:0] ana_hold;

    // Control nibbles; unknown widths are kept whole so software reads back
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            func_sel_r <= sfio_pkg::SFIO_NIB_RESET;
            group_pu_r <= sfio_pkg::SFIO_NIB_RESET;
            ser_pu_r <= sfio_pkg::SFIO_NIB_RESET;
            ana_sel_r <= sfio_pkg::SFIO_NIB_RESET; // [R7]
            ana_dir_r <= sfio_pkg::SFIO_NIB_RESET; // [R3]
            chan_sel_r <= sfio_pkg::SFIO_NIB_RESET; // [R7]
            ser_dir_r <= sfio_pkg::SFIO_NIB_RESET; // [R11]
            group_dir_r <= sfio_pkg::SFIO_NIB_RESET; // [R17]
        end
        else if (rf_wr)
        begin
            case (rf_addr)
                sfio_pkg::SFIO_ADDR_FUNC_SEL: func_sel_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_GROUP_PU: group_pu_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_SER_PU: ser_pu_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_ANA_SEL: ana_sel_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_ANA_DIR: ana_dir_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_CHAN_SEL: chan_sel_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_SER_DIR: ser_dir_r <= rf_wdata;
                sfio_pkg::SFIO_ADDR_GROUP_DIR: group_dir_r <= rf_wdata;
                default:
                begin
                end
            endcase
        end
    end

    // Latches load whatever the direction, so output data can be staged first
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ana_lat_r <= sfio_pkg::SFIO_NIB_RESET; // [R3]
            ser_lat_r <= sfio_pkg::SFIO_NIB_RESET; // [R11]
            od_lat_r <= sfio_pkg::SFIO_NIB_RESET; // [R17]
        end
        else if (dm_wr)
        begin
            case (dm_addr)
                sfio_pkg::SFIO_ADDR_ANA_DATA: ana_lat_r <= dm_wdata; // [R1] [R21]
                sfio_pkg::SFIO_ADDR_SER_DATA: ser_lat_r <= dm_wdata; // [R9] [R21]
                sfio_pkg::SFIO_ADDR_OD_DATA: od_lat_r <= dm_wdata; // [R15] [R21]
                default:
                begin
                end
            endcase
        end
    end

    // Timer output starts at 1 on timer reset, else flips on each match
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_out_r <= 1'b1;
        else if (timer_reset)
            timer_out_r <= 1'b1; // [R13]
        else if (timer_match)
            timer_out_r <= ~timer_out_r; // [R13]
    end

    assign serial_on = func_sel_r[sfio_pkg::SFIO_SERIAL_EN_BIT]; // [R12]
    assign timer_on = func_sel_r[sfio_pkg::SFIO_TIMER_OUT_BIT]; // [R13]
    assign od_dir = {4{group_dir_r[sfio_pkg::SFIO_OD_GROUP_BIT]}}; // [R15]

    // Analog port: push-pull; analog select does not block an output drive
    assign ana_pin_out = ana_lat_r; // [R1]
    assign ana_pin_oe = ana_dir_r; // [R2] [R22]
    assign analog_pin_enable = ana_sel_r; // [R4]
    assign converter_channel = chan_sel_r[1:0] & sfio_pkg::SFIO_CHAN_MASK; // [R6]
    assign reference_pin_enable = |ana_sel_r; // [R5]
    // Analog pins read back the latch; their level is not a logic value
    assign ana_hold = ana_dir_r | ana_sel_r; // [R4]

    // Serial port pin roles; clock drive depends on internal clock source
    always_comb
    begin
        ser_drive = ser_dir_r; // [R9]
        ser_pin_out = ser_lat_r;
        ser_use_pin = ~ser_dir_r; // [R14]
        if (serial_on)
        begin
            ser_drive[sfio_pkg::SFIO_SCK_PIN] = serial_clk_internal; // [R12]
            ser_pin_out[sfio_pkg::SFIO_SCK_PIN] = serial_clk_out;
            ser_use_pin[sfio_pkg::SFIO_SCK_PIN] = ~serial_clk_internal; // [R14]
            ser_drive[sfio_pkg::SFIO_SO_PIN] = 1'b1;
            ser_pin_out[sfio_pkg::SFIO_SO_PIN] = serial_data_out;
            ser_use_pin[sfio_pkg::SFIO_SO_PIN] = 1'b0; // [R14]
            ser_drive[sfio_pkg::SFIO_SI_PIN] = 1'b0;
            ser_use_pin[sfio_pkg::SFIO_SI_PIN] = 1'b1; // [R14]
        end
        if (timer_on)
        begin
            ser_drive[sfio_pkg::SFIO_TMR_PIN] = 1'b1; // [R13]
            ser_pin_out[sfio_pkg::SFIO_TMR_PIN] = timer_out_r;
            ser_use_pin[sfio_pkg::SFIO_TMR_PIN] = 1'b0; // [R14]
        end
    end

    // Open drain: only a driven 0 pulls the pin, a 1 releases it
    assign ser_pin_oe = ser_drive & ~ser_pin_out; // [R9] [R22]
    assign ser_pullup_en = ser_pu_r; // [R10]
    assign serial_data_in = ser_pin_in[sfio_pkg::SFIO_SI_PIN];
    assign serial_clk_in = ser_pin_in[sfio_pkg::SFIO_SCK_PIN];

    assign od_pin_out = od_lat_r;
    assign od_pin_oe = od_dir & ~od_lat_r; // [R15] [R22]
    assign od_pullup_en = {4{group_pu_r[sfio_pkg::SFIO_OD_GROUP_BIT]}}; // [R16]

    // Reference pin reads 0 while claimed by the converter
    assign in_read = {2'h0, in_pin[1] & ~reference_pin_enable, in_pin[0]}; // [R18] [R20]

    always_comb
    begin
        case (dm_addr)
            sfio_pkg::SFIO_ADDR_ANA_DATA:
                dm_rdata = (ana_hold & ana_lat_r) | (~ana_hold & ana_pin_in); // [R2] [R4]
            sfio_pkg::SFIO_ADDR_SER_DATA:
                dm_rdata = (~ser_use_pin & ser_lat_r) | (ser_use_pin & ser_pin_in); // [R14]
            sfio_pkg::SFIO_ADDR_OD_DATA:
                dm_rdata = (od_dir & od_lat_r) | (~od_dir & od_pin_in); // [R15]
            sfio_pkg::SFIO_ADDR_IN_DATA:
                dm_rdata = in_read; // [R19]
            default:
                dm_rdata = 4'h0;
        endcase
    end

    always_comb
    begin
        case (rf_addr)
            sfio_pkg::SFIO_ADDR_FUNC_SEL: rf_rdata = func_sel_r;
            sfio_pkg::SFIO_ADDR_GROUP_PU: rf_rdata = group_pu_r;
            sfio_pkg::SFIO_ADDR_SER_PU: rf_rdata = ser_pu_r;
            sfio_pkg::SFIO_ADDR_ANA_SEL: rf_rdata = ana_sel_r;
            sfio_pkg::SFIO_ADDR_ANA_DIR: rf_rdata = ana_dir_r;
            sfio_pkg::SFIO_ADDR_CHAN_SEL: rf_rdata = chan_sel_r;
            sfio_pkg::SFIO_ADDR_SER_DIR: rf_rdata = ser_dir_r;
            sfio_pkg::SFIO_ADDR_GROUP_DIR: rf_rdata = group_dir_r;
            default: rf_rdata = 4'h0;
        endcase
    end
endmodule

/* test/sfio_pins.sv */
`timescale 1ns/1ps
module sfio_pins (
    input wire logic [3:0] ana_pin_out,
    input wire logic [3:0] ana_pin_oe,
    input wire logic [3:0] ser_pin_oe,
    input wire logic [3:0] ser_pullup_en,
    input wire logic [3:0] od_pin_oe,
    input wire logic [3:0] od_pullup_en,
    input wire logic [3:0] ext_level,
    output logic [3:0] ana_pin_in,
    output logic [3:0] ser_pin_in,
    output logic [3:0] od_pin_in
);
    // Push-pull drive wins over the outside source
    assign ana_pin_in = (ana_pin_oe & ana_pin_out) | (~ana_pin_oe & ext_level);
    // Open drain only pulls low; pull-up lifts a released line
    assign ser_pin_in = ~ser_pin_oe & (ext_level | ser_pullup_en);
    assign od_pin_in = ~od_pin_oe & (ext_level | od_pullup_en);
endmodule

/* test/sfio_ports_chk.sv */
`timescale 1ns/1ps
module sfio_ports_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [6:0] rf_addr,
    input wire logic rf_wr,
    input wire logic [3:0] rf_wdata,
    input wire logic [6:0] dm_addr,
    input wire logic [3:0] dm_rdata,
    input wire logic [3:0] ana_pin_in,
    input wire logic [3:0] ana_pin_out,
    input wire logic [3:0] ana_pin_oe,
    input wire logic [3:0] analog_pin_enable,
    input wire logic [1:0] converter_channel,
    input wire logic reference_pin_enable,
    input wire logic [3:0] od_pin_out,
    input wire logic [3:0] od_pin_oe,
    input wire logic [1:0] in_pin
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    sequence rf_put(a);
        rf_wr && rf_addr == a;
    endsequence
    dir_write_a: assert property (rf_put(7'h1c) |=> ana_pin_oe == $past(rf_wdata))
        else $error("direction write lost");
    ana_sel_a: assert property (rf_put(7'h1b) |=> analog_pin_enable == $past(rf_wdata))
        else $error("analog select write lost");
    chan_write_a: assert property (rf_put(7'h22) |=> converter_channel == $past(rf_wdata[1:0]))
        else $error("channel write lost");
    ref_follow_a: assert property (reference_pin_enable == |analog_pin_enable)
        else $error("reference enable wrong");
    ana_read_a: assert property (dm_addr == 7'h72 && analog_pin_enable == 4'h0 |->
        dm_rdata == ((ana_pin_oe & ana_pin_out) | (~ana_pin_oe & ana_pin_in)))
        else $error("analog port read wrong");
    ana_sel_read_a: assert property (dm_addr == 7'h72 |->
        ((dm_rdata ^ ana_pin_out) & analog_pin_enable) == 4'h0)
        else $error("analog input read wrong");
    in_read_a: assert property (dm_addr == 7'h6f |->
        dm_rdata == {2'h0, in_pin[1] & ~reference_pin_enable, in_pin[0]})
        else $error("input port read wrong");
    od_release_a: assert property ((od_pin_oe & od_pin_out) == 4'h0)
        else $error("open drain drives high");
    reset_clear_a: assert property ($rose(reset_n) |-> ana_pin_oe == 4'h0 && od_pin_oe == 4'h0
        && analog_pin_enable == 4'h0 && converter_channel == 2'h0)
        else $error("reset state wrong");
endmodule
bind sfio_ports sfio_ports_chk sfio_ports_chk_i (.*);

/* test/test_shared_function_io_ports.sv */
`timescale 1ns/1ps
module test_shared_function_io_ports;
    logic ref_clk, reset_n, rf_wr, dm_wr, serial_clk_internal, serial_clk_out, serial_data_out;
    logic timer_reset, timer_match, reference_pin_enable, serial_data_in, serial_clk_in;
    logic [6:0] rf_addr, dm_addr;
    logic [3:0] rf_wdata, dm_wdata, ext_level, rf_rdata, dm_rdata, ana_pin_in, ana_pin_out;
    logic [3:0] ana_pin_oe, analog_pin_enable, ser_pin_in, ser_pin_out, ser_pin_oe, ser_pullup_en;
    logic [3:0] od_pin_in, od_pin_out, od_pin_oe, od_pullup_en;
    logic [1:0] converter_channel, in_pin;
    int err_count = 0;
    int tests_run = 0;
    sfio_ports sfio_ports_i (.*);
    sfio_pins sfio_pins_i (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic rf, input logic [6:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        {rf_addr, dm_addr, rf_wdata, dm_wdata} <= {a, a, d, d};
        rf_wr <= rf;
        dm_wr <= !rf;
        @(posedge ref_clk);
        {rf_wr, dm_wr} <= 2'h0;
        #5;
    endtask
    task automatic rd(input logic rf, input logic [6:0] a, input logic [3:0] exp);
        @(posedge ref_clk);
        {rf_addr, dm_addr} <= {a, a};
        #5;
        check(rf ? rf_rdata : dm_rdata, exp);
    endtask
    task automatic t_analog;
        check(ana_pin_oe | od_pin_oe, 4'h0);
        put(0, 7'h72, 4'h5);
        rd(0, 7'h72, 4'ha);
        put(1, 7'h1c, 4'h3);
        check(ana_pin_oe & ana_pin_out, 4'h1);
        rd(1, 7'h1c, 4'h3);
        rd(0, 7'h72, 4'h9);
        put(1, 7'h1b, 4'h4);
        check({3'h0, reference_pin_enable}, 4'h1);
        check(analog_pin_enable, 4'h4);
        rd(0, 7'h72, 4'hd);
        rd(0, 7'h6f, 4'h1);
        put(1, 7'h1b, 4'h0);
        put(0, 7'h6f, 4'hf);
        rd(0, 7'h6f, 4'h3);
        put(1, 7'h22, 4'hf);
        check({2'h0, converter_channel}, 4'h3);
    endtask
    task automatic t_serial;
        put(0, 7'h73, 4'h6);
        put(1, 7'h2b, 4'hf);
        check(ser_pin_oe, 4'h9);
        put(1, 7'h2b, 4'h0);
        rd(0, 7'h73, 4'ha);
        put(1, 7'h2b, 4'hf);
        rd(0, 7'h73, 4'h6);
        put(1, 7'h0d, 4'h5);
        check(ser_pullup_en, 4'h5);
        put(1, 7'h0b, 4'h9);
        check({ser_pin_out[3], ser_pin_out[1], 1'b0, serial_data_in}, 4'h9);
        @(posedge ref_clk);
        timer_match <= 1'b1;
        @(posedge ref_clk);
        timer_match <= 1'b0;
        #5;
        check({3'h0, ser_pin_out[3]}, 4'h0);
        @(posedge ref_clk);
        timer_reset <= 1'b1;
        @(posedge ref_clk);
        timer_match <= 1'b1;
        #5;
        check({3'h0, ser_pin_out[3]}, 4'h1);
        @(posedge ref_clk);
        {timer_reset, timer_match} <= 2'h0;
        #5;
        check({3'h0, ser_pin_out[3]}, 4'h1);
        rd(0, 7'h73, 4'h7);
        check({3'h0, serial_clk_in}, 4'h1);
        @(posedge ref_clk);
        serial_clk_internal <= 1'b1;
        #5;
        check(ser_pin_oe, 4'h3);
        rd(0, 7'h73, 4'h6);
    endtask
    task automatic t_od;
        put(0, 7'h6e, 4'h5);
        rd(0, 7'h6e, 4'ha);
        put(1, 7'h2c, 4'h4);
        check(od_pin_oe, 4'ha);
        check(od_pin_out, 4'h5);
        rd(0, 7'h6e, 4'h5);
        put(1, 7'h0c, 4'h4);
        check(od_pullup_en, 4'hf);
        rd(1, 7'h3f, 4'h0);
    endtask
    task automatic t_reset;
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #5;
        check(ana_pin_oe | ser_pin_oe | od_pin_oe, 4'h0);
        check(ana_pin_out | ser_pin_out | od_pin_out, 4'h0);
        check(analog_pin_enable | {2'h0, converter_channel}, 4'h0);
        check(ser_pullup_en | od_pullup_en, 4'h0);
        rd(0, 7'h73, 4'ha);
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        {reset_n, rf_wr, dm_wr, serial_clk_internal, serial_clk_out, serial_data_out} = 6'h00;
        {timer_reset, timer_match, rf_addr, dm_addr, rf_wdata, dm_wdata} = '0;
        {ext_level, in_pin} = {4'ha, 2'h3};
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #5;
        t_analog;
        t_serial;
        t_od;
        t_reset;
        stop_test;
    end
    initial
    begin
        repeat (1000) @(posedge ref_clk);
        err_count++;
        stop_test;
    end
endmodule
